// ==== hw/udcrt_timer.sv ====
/*
 Up/down capture/reload 16-bit timer with baud ticks and clock output, AHB-Lite register slave.
 Assumes ref_clk is the oscillator clock, pins are asynchronous, and the core gates interrupts.
*/
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module udcrt_timer
(
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	input  wire udcrt_pkg::udcrt_ahb_req_t ahb_req,
	output udcrt_pkg::udcrt_ahb_rsp_t      ahb_rsp,
	input  wire logic                      event_count_pin_in,
	input  wire logic                      trigger_direction_pin,
	output logic                           clock_output_pin_out,
	output logic                           clock_output_pin_oe_n,
	input  wire logic                      timer_int_enable,
	output logic                           timer_irq,
	output logic                           rx_baud_tick,
	output logic                           tx_baud_tick
);
	import udcrt_pkg::*;

	udcrt_bus_state_t          bus_state;
	udcrt_bus_state_t          next_bus_state;
	logic [`UDCRT_ADDR_W-1:0]  addr_q;
	logic [31:0]               hrdata;
	udcrt_ctrl_t               ctrl;
	udcrt_mode_t               mode;
	logic [15:0]               count;
	logic [15:0]               reload;
	logic [3:0]                phase;
	logic                      half;
	logic                      evt_pend;
	logic [1:0]                pin_raw;
	logic [1:0]                pin_level;
	logic [1:0]                pin_fall;
	udcrt_op_mode_t            op_mode;
	logic                      take;
	logic                      wr_en;
	logic [7:0]                wdata;
	logic                      wr_ctrl;
	logic                      wr_mode;
	logic                      wr_rl;
	logic                      wr_rh;
	logic                      wr_cl;
	logic                      wr_ch;
	logic                      baud;
	logic                      clkout;
	logic                      updown;
	logic                      count_up;
	logic                      mc_apply;
	logic                      cnt_tick;
	logic                      roll_up;
	logic                      underflow;
	logic                      rollover;
	logic                      reload_on_ovf;
	logic                      trig;
	logic                      capture_evt;
	logic                      trig_reload;
	logic                      tf_set;
	logic                      exf_set;
	logic                      exf_toggle;

	function automatic logic hit(input logic [`UDCRT_ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {2'h0, idx, 2'h0});
	endfunction

	// bus slave: writes take no wait state, reads take one
	assign take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

	always_comb
	begin
		next_bus_state = BUS_IDLE;
		case (bus_state)
			BUS_READ_WAIT: next_bus_state = BUS_READ_DONE;
			BUS_IDLE, BUS_WRITE, BUS_READ_DONE:
				if (take)
					next_bus_state = ahb_req.hwrite ? BUS_WRITE : BUS_READ_WAIT;
			default: next_bus_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			bus_state <= BUS_IDLE;
		else
			bus_state <= next_bus_state;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			addr_q <= '0;
		else if (take && bus_state != BUS_READ_WAIT)
			addr_q <= ahb_req.haddr;
	end

	assign wr_en   = (bus_state == BUS_WRITE);
	assign wdata   = ahb_req.hwdata[7:0];
	assign wr_ctrl = wr_en & hit(addr_q, `UDCRT_IDX_CONTROL);
	assign wr_mode = wr_en & hit(addr_q, `UDCRT_IDX_MODE);
	assign wr_rl   = wr_en & hit(addr_q, `UDCRT_IDX_RELOAD_LO);
	assign wr_rh   = wr_en & hit(addr_q, `UDCRT_IDX_RELOAD_HI);
	assign wr_cl   = wr_en & hit(addr_q, `UDCRT_IDX_COUNT_LO);
	assign wr_ch   = wr_en & hit(addr_q, `UDCRT_IDX_COUNT_HI);

	// unmapped addresses read zero
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			hrdata <= 32'h0000_0000;
		else if (bus_state == BUS_READ_WAIT)
		begin
			hrdata <= 32'h0000_0000;
			if (hit(addr_q, `UDCRT_IDX_CONTROL))
				hrdata[7:0] <= ctrl;
			else if (hit(addr_q, `UDCRT_IDX_MODE))
				hrdata[7:0] <= mode & `UDCRT_MODE_USED;
			else if (hit(addr_q, `UDCRT_IDX_RELOAD_LO))
				hrdata[7:0] <= reload[7:0];
			else if (hit(addr_q, `UDCRT_IDX_RELOAD_HI))
				hrdata[7:0] <= reload[15:8];
			else if (hit(addr_q, `UDCRT_IDX_COUNT_LO))
				hrdata[7:0] <= count[7:0];
			else if (hit(addr_q, `UDCRT_IDX_COUNT_HI))
				hrdata[7:0] <= count[15:8];
		end
	end

	always_comb
	begin
		ahb_rsp.hreadyout = (bus_state != BUS_READ_WAIT);
		ahb_rsp.hresp     = 1'b0;
		ahb_rsp.hrdata    = hrdata;
	end

	// machine cycle phase and the half-rate step used for baud and clock out
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			phase <= 4'h0;
			half  <= 1'b0;
		end
		else
		begin
			phase <= (phase == `UDCRT_OSC_PER_MC - 4'h1) ? 4'h0 : phase + 4'h1;
			half  <= ~half;
		end
	end

	assign pin_raw = {trigger_direction_pin, event_count_pin_in};

	genvar g;
	for (g = 0; g < 2; g++)
	begin : g_pin
		udcrt_pin_sampler u_sampler
		(
			.ref_clk   (ref_clk),
			.srst      (srst),
			.pin_async (pin_raw[g]),
			.sample    (phase == `UDCRT_PH_SAMPLE),
			.level     (pin_level[g]),
			.fall      (pin_fall[g])
		);
	end

	// event held until the apply phase of the next cycle
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			evt_pend <= 1'b0;
		else if (pin_fall[0])
			evt_pend <= 1'b1;
		else if (phase == `UDCRT_PH_APPLY)
			evt_pend <= 1'b0;
	end

	assign baud   = ctrl.rx_serial_clock_select | ctrl.tx_serial_clock_select;
	assign clkout = mode.clock_output_enable & ~ctrl.count_source_select;

	always_comb
	begin
		if (!ctrl.run_control)
			op_mode = UDCRT_OFF;
		else if (baud)
			op_mode = UDCRT_BAUD;
		else if (ctrl.capture_reload_select)
			op_mode = UDCRT_CAPTURE;
		else
			op_mode = UDCRT_AUTO_RELOAD;
	end

	// direction pin steers only with down counting enabled
	assign updown   = (op_mode == UDCRT_AUTO_RELOAD) & mode.down_count_enable;
	assign count_up = ~updown | pin_level[1];
	assign mc_apply = (phase == `UDCRT_PH_APPLY);

	always_comb
	begin
		if (op_mode == UDCRT_OFF)
			cnt_tick = 1'b0;
		else if (ctrl.count_source_select)
			cnt_tick = evt_pend & mc_apply;
		else if (baud || clkout)
			cnt_tick = half;
		else
			cnt_tick = mc_apply;
	end

	assign roll_up   = cnt_tick & count_up & (count == `UDCRT_COUNT_MAX);
	// down count underflows at the reload value
	assign underflow = cnt_tick & ~count_up & (count == reload);
	assign rollover  = roll_up | underflow;
	// serial clocking forces reload on overflow
	assign reload_on_ovf = ~ctrl.capture_reload_select | baud;

	assign trig        = pin_fall[1] & ctrl.external_trigger_enable & ~baud;
	assign capture_evt = trig & ctrl.capture_reload_select;
	assign trig_reload = trig & ~ctrl.capture_reload_select & ~mode.down_count_enable;

	// overflow and trigger reloads; software byte writes win
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			count <= {`UDCRT_BYTE_RST, `UDCRT_BYTE_RST};
		else
		begin
			if (roll_up)
				count <= reload_on_ovf ? reload : count + 16'h0001;
			else if (underflow)
				count <= `UDCRT_COUNT_MAX;
			else if (trig_reload)
				count <= reload;
			else if (cnt_tick)
				count <= count_up ? count + 16'h0001 : count - 16'h0001;
			if (wr_cl)
				count[7:0] <= wdata;
			if (wr_ch)
				count[15:8] <= wdata;
		end
	end

	// one reload pair serves reload, baud and clock out; capture beats a write
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			reload <= {`UDCRT_BYTE_RST, `UDCRT_BYTE_RST};
		else
		begin
			if (wr_rl)
				reload[7:0] <= wdata;
			if (wr_rh)
				reload[15:8] <= wdata;
			if (capture_evt)
				reload <= count;
		end
	end

	// overflow flag in capture and reload modes
	// flag set on the very rollover edge
	assign tf_set     = rollover & ~baud & ~clkout;
	assign exf_set    = capture_evt | trig_reload;
	// edge flag as seventeenth count bit
	assign exf_toggle = rollover & updown;

	// control layout; hardware set beats software clear
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			ctrl <= udcrt_ctrl_t'(`UDCRT_CONTROL_RST);
		else
		begin
			if (wr_ctrl)
				ctrl <= udcrt_ctrl_t'(wdata);
			if (tf_set)
				ctrl.overflow_flag <= 1'b1;
			if (exf_set)
				ctrl.external_edge_flag <= 1'b1;
			else if (exf_toggle)
				ctrl.external_edge_flag <= ~ctrl.external_edge_flag;
		end
	end

	// mode register keeps two bits, reserved read zero
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			mode <= udcrt_mode_t'(`UDCRT_MODE_RST);
		else if (wr_mode)
			mode <= udcrt_mode_t'(wdata & `UDCRT_MODE_USED);
	end

	// flag request; edge flag silent in up/down mode
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			timer_irq <= 1'b0;
		else
			timer_irq <= timer_int_enable & (ctrl.overflow_flag | (ctrl.external_edge_flag & ~mode.down_count_enable));
	end

	// half-rate steps give the 50 percent clock
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			clock_output_pin_out  <= 1'b0;
			clock_output_pin_oe_n <= 1'b1;
			rx_baud_tick          <= 1'b0;
			tx_baud_tick          <= 1'b0;
		end
		else
		begin
			clock_output_pin_oe_n <= ~clkout;
			if (clkout && rollover)
				clock_output_pin_out <= ~clock_output_pin_out;
			rx_baud_tick <= rollover & ctrl.rx_serial_clock_select;
			tx_baud_tick <= rollover & ctrl.tx_serial_clock_select;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_cnt_fall;
		pin_fall[0] && ctrl.count_source_select && ctrl.run_control;
	endsequence

	sequence s_applied;
		cnt_tick || !ctrl.run_control || !ctrl.count_source_select;
	endsequence

	a_timer_rate: assert property (
		op_mode == UDCRT_AUTO_RELOAD && !ctrl.count_source_select && !clkout && !mode.down_count_enable
		&& !mc_apply && !trig_reload && !wr_cl && !wr_ch |=> count == $past(count))
		else $error("timer function stepped off the apply phase");

	a_event_sample: assert property (
		pin_fall[0] |-> $past(phase) == `UDCRT_PH_SAMPLE)
		else $error("event edge not taken at the sample phase");

	a_event_apply: assert property (
		s_cnt_fall |-> ##[1:12] s_applied)
		else $error("detected event not applied within a machine cycle");

	a_off_hold: assert property (
		!ctrl.run_control && !trig_reload && !wr_cl && !wr_ch |=> count == $past(count))
		else $error("count moved while stopped");

	a_capture_copy: assert property (
		capture_evt && !wr_ctrl |=> reload == $past(count) && ctrl.external_edge_flag)
		else $error("capture missed count or edge flag");

	a_up_reload: assert property (
		roll_up && reload_on_ovf && !wr_cl && !wr_ch |=> count == $past(reload))
		else $error("overflow did not reload");

	a_down_under: assert property (
		underflow && !clkout && !wr_cl && !wr_ch && !wr_ctrl |=> count == `UDCRT_COUNT_MAX && ctrl.overflow_flag)
		else $error("underflow did not load all ones and set flag");

	a_exf_toggle: assert property (
		exf_toggle && !wr_ctrl |=> ctrl.external_edge_flag != $past(ctrl.external_edge_flag))
		else $error("edge flag did not toggle on rollover");

	a_flag_sticky: assert property (
		ctrl.overflow_flag && !wr_ctrl |=> ctrl.overflow_flag)
		else $error("overflow flag cleared by hardware");

	a_baud_no_tf: assert property (
		baud && !ctrl.overflow_flag && !wr_ctrl |=> !ctrl.overflow_flag)
		else $error("overflow flag set while serial clocking");

	a_clk_toggle: assert property (
		clkout && rollover |=> clock_output_pin_out != $past(clock_output_pin_out))
		else $error("clock out pin missed a rollover");

	a_irq_gate: assert property (
		!timer_int_enable |=> !timer_irq)
		else $error("interrupt request while disabled");

endmodule

// ==== hw/udcrt_map.svh ====
/*
 Register indices, reset values and machine-cycle timing of the up/down capture/reload timer.
 Assumes the core clock is the oscillator clock; included by the package and the bench.
*/
`ifndef UDCRT_MAP_SVH
`define UDCRT_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define UDCRT_IDX_CONTROL    8'hC8
`define UDCRT_IDX_MODE       8'hC9
`define UDCRT_IDX_RELOAD_LO  8'hCA
`define UDCRT_IDX_RELOAD_HI  8'hCB
`define UDCRT_IDX_COUNT_LO   8'hCC
`define UDCRT_IDX_COUNT_HI   8'hCD
`define UDCRT_ADDR_W         12

// reset values
`define UDCRT_CONTROL_RST    8'h00
`define UDCRT_MODE_RST       8'h00
`define UDCRT_BYTE_RST       8'h00
`define UDCRT_MODE_USED      8'h03

// machine cycle timing, in oscillator periods
`define UDCRT_OSC_PER_MC     4'hC
`define UDCRT_PH_APPLY       4'h4
`define UDCRT_PH_SAMPLE      4'h9
`define UDCRT_COUNT_MAX      16'hFFFF

`endif

// ==== hw/udcrt_pkg.sv ====
/*
 Types of the up/down capture/reload timer: register layouts, bus carriers and state enums.
 Assumes udcrt_map.svh is on the include path.
*/
`include "udcrt_map.svh"

package udcrt_pkg;

	typedef struct packed {
		logic overflow_flag;
		logic external_edge_flag;
		logic rx_serial_clock_select;
		logic tx_serial_clock_select;
		logic external_trigger_enable;
		logic run_control;
		logic count_source_select;
		logic capture_reload_select;
	} udcrt_ctrl_t;

	typedef struct packed {
		logic [5:0] reserved;
		logic       clock_output_enable;
		logic       down_count_enable;
	} udcrt_mode_t;

	typedef struct packed {
		logic                       hsel;
		logic [`UDCRT_ADDR_W-1:0]   haddr;
		logic [1:0]                 htrans;
		logic                       hwrite;
		logic [2:0]                 hsize;
		logic [31:0]                hwdata;
		logic                       hready;
	} udcrt_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} udcrt_ahb_rsp_t;

	typedef enum logic [1:0] {UDCRT_OFF, UDCRT_AUTO_RELOAD, UDCRT_CAPTURE, UDCRT_BAUD} udcrt_op_mode_t;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} udcrt_bus_state_t;

endpackage

// ==== hw/udcrt_pin_sampler.sv ====
/*
 Pin sampler: two-flop synchroniser, then one sample per machine cycle and a falling-edge pulse.
 Assumes the sample strobe is one clock wide, once per machine cycle, on the same clock.
*/
`timescale 1ns/1ps

module udcrt_pin_sampler
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic pin_async,
	input  wire logic sample,
	output logic      level,
	output logic      fall
);
	logic sync_a;
	logic sync_b;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end
		else
		begin
			sync_a <= pin_async;
			sync_b <= sync_a;
		end
	end

	// high in one sample, low in the next gives a one-clock pulse
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			level <= 1'b1;
			fall  <= 1'b0;
		end
		else
		begin
			fall <= sample & level & ~sync_b;
			if (sample)
				level <= sync_b;
		end
	end

endmodule

// ==== tb/udcrt_pin_partner.sv ====
/*
 Far-side model of the timer: event and trigger/direction pins, serial tick and clock-out counters.
 Assumes the timer's clock; tasks are called by the bench just after a rising edge.
*/
`timescale 1ns/1ps

module udcrt_pin_partner
(
	input  wire logic ref_clk,
	input  wire logic clk_out,
	input  wire logic clk_oe_n,
	input  wire logic rx_tick,
	input  wire logic tx_tick,
	output logic      event_wire,
	output logic      trig_pin
);
	logic event_drv = 1'b1;
	logic last_out  = 1'b0;
	int   rx_cnt    = 0;
	int   tx_cnt    = 0;
	int   toggles   = 0;

	// shared pin: the timer drives it in clock-out mode, else the source over the pull-up
	assign event_wire = clk_oe_n ? event_drv : clk_out;
	initial trig_pin = 1'b1;

	always @(posedge ref_clk)
	begin
		rx_cnt   <= rx_cnt + int'(rx_tick);
		tx_cnt   <= tx_cnt + int'(tx_tick);
		toggles  <= toggles + int'(clk_out !== last_out);
		last_out <= clk_out;
	end

	// each level held two machine cycles
	task automatic pulse_event(input int n);
		repeat (n)
		begin
			event_drv <= 1'b0;
			repeat (24) @(posedge ref_clk);
			event_drv <= 1'b1;
			repeat (24) @(posedge ref_clk);
		end
	endtask

	// trigger levels held two machine cycles
	task automatic drive_trig(input logic a, input logic b);
		trig_pin <= a;
		repeat (24) @(posedge ref_clk);
		trig_pin <= b;
		repeat (24) @(posedge ref_clk);
	endtask
endmodule

// ==== tb/tb.sv ====
/*
 Self-checking bench of the up/down capture/reload timer, register access over AHB-Lite.
 Assumes udcrt_map.svh on the include path and the pin partner model beside it.
*/
`timescale 1ns/1ps
`include "udcrt_map.svh"

module tb;
	import udcrt_pkg::*;

	localparam logic [7:0] CTL = `UDCRT_IDX_CONTROL;
	localparam logic [7:0] MOD = `UDCRT_IDX_MODE;
	localparam logic [7:0] RLO = `UDCRT_IDX_RELOAD_LO;
	localparam logic [7:0] RHI = `UDCRT_IDX_RELOAD_HI;
	localparam logic [7:0] CLO = `UDCRT_IDX_COUNT_LO;
	localparam logic [7:0] CHI = `UDCRT_IDX_COUNT_HI;

	logic           ref_clk = 1'b0;
	logic           srst    = 1'b1;
	logic           hsel    = 1'b0;
	logic [11:0]    haddr   = 12'h000;
	logic [1:0]     htrans  = 2'h0;
	logic           hwrite  = 1'b0;
	logic [31:0]    hwdata  = 32'h0;
	logic           int_en  = 1'b0;
	udcrt_ahb_req_t ahb_req;
	udcrt_ahb_rsp_t ahb_rsp;
	logic           evt_wire;
	logic           trig;
	logic           clk_out;
	logic           clk_oe_n;
	logic           irq;
	logic           rx_tick;
	logic           tx_tick;
	logic [7:0]     rd;
	int             mismatches = 0;
	int             tests_run = 0;

	assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
		hwdata: hwdata, hready: ahb_rsp.hreadyout};
	always #10 ref_clk = ~ref_clk;

	udcrt_timer u_dut (.ref_clk(ref_clk), .srst(srst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
		.event_count_pin_in(evt_wire), .trigger_direction_pin(trig), .clock_output_pin_out(clk_out),
		.clock_output_pin_oe_n(clk_oe_n), .timer_int_enable(int_en), .timer_irq(irq),
		.rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick));

	udcrt_pin_partner u_pins (.ref_clk(ref_clk), .clk_out(clk_out), .clk_oe_n(clk_oe_n),
		.rx_tick(rx_tick), .tx_tick(tx_tick), .event_wire(evt_wire), .trig_pin(trig));

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic clocks(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// no local limit: a stuck slave is ended by the watchdog
	task automatic wait_rdy;
		@(posedge ref_clk);
		while (ahb_rsp.hreadyout !== 1'b1)
			@(posedge ref_clk);
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {2'h0, idx, 2'h0};
		hwrite <= wr;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = ahb_rsp.hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(what, {8'h00, rd}, {8'h00, exp});
		check("okay response", 16'(ahb_rsp.hresp), 16'h0000);
	endtask

	task automatic load(input logic [7:0] rl, input logic [7:0] rh, input logic [7:0] cl, input logic [7:0] ch);
		wr(RLO, rl);
		wr(RHI, rh);
		wr(CLO, cl);
		wr(CHI, ch);
	endtask

	task automatic t_reset;
		rchk("control", CTL, `UDCRT_CONTROL_RST);
		rchk("mode", MOD, `UDCRT_MODE_RST);
		rchk("unmapped", 8'hC0, 8'h00);
		wr(MOD, 8'hFF);
		rchk("mode used bits", MOD, `UDCRT_MODE_USED);
		wr(MOD, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_timer;
		load(8'h34, 8'h12, 8'h00, 8'h00);
		wr(CTL, 8'h04);
		clocks(120);
		wr(CTL, 8'h00);
		bus(1'b0, CLO, 8'h00);
		check("timer rate", 16'(rd >= 8'h0A && rd <= 8'h0B), 16'h0001);
		load(8'h34, 8'h12, 8'hFD, 8'hFF);
		int_en <= 1'b1;
		wr(CTL, 8'h04);
		clocks(60);
		check("irq", 16'(irq), 16'h0001);
		rchk("overflow flag", CTL, 8'h84);
		wr(CTL, 8'h80);
		rchk("reloaded", CHI, 8'h12);
		clocks(30);
		rchk("flag kept", CTL, 8'h80);
		wr(CTL, 8'h00);
		clocks(3);
		check("irq cleared", 16'(irq), 16'h0000);
		int_en <= 1'b0;
		$display("test timer done");
	endtask

	task automatic t_counter;
		load(8'h00, 8'h00, 8'h00, 8'h00);
		wr(CTL, 8'h06);
		u_pins.pulse_event(5);
		clocks(36);
		wr(CTL, 8'h00);
		rchk("event count", CLO, 8'h05);
		$display("test counter done");
	endtask

	task automatic t_trig(input logic [7:0] ctl, input logic [7:0] idx, input logic [7:0] ec, input logic [7:0] ev);
		load(8'h00, 8'h50, 8'hF0, 8'hFF);
		wr(CTL, ctl);
		u_pins.drive_trig(1'b0, 1'b1);
		clocks(180);
		rchk("trigger flags", CTL, ec);
		wr(CTL, 8'h00);
		rchk("trigger result", idx, ev);
		$display("test trigger done");
	endtask

	task automatic t_updown(input logic dir, input logic [7:0] cl, input logic [7:0] ch, input logic [7:0] ctl,
		input logic [7:0] ec, input logic [7:0] eh);
		wr(MOD, 8'h01);
		u_pins.drive_trig(dir, dir);
		load(8'h00, 8'h40, cl, ch);
		int_en <= 1'b1;
		wr(CTL, ctl);
		clocks(48);
		rchk("updown flags", CTL, ec);
		wr(CTL, ec & 8'h7B);
		clocks(3);
		check("updown irq", 16'(irq), 16'h0000);
		rchk("updown count", CHI, eh);
		int_en <= 1'b0;
		wr(MOD, 8'h00);
		$display("test updown done");
	endtask

	task automatic t_baud(input logic [7:0] sel);
		int rx0;
		int tx0;
		int n;
		load(8'hFC, 8'hFF, 8'hFC, 8'hFF);
		rx0 = u_pins.rx_cnt;
		tx0 = u_pins.tx_cnt;
		wr(CTL, sel | 8'h04);
		clocks(160);
		rchk("baud no flag", CTL, sel | 8'h04);
		wr(CTL, 8'h00);
		n = sel[4] ? u_pins.tx_cnt - tx0 : u_pins.rx_cnt - rx0;
		check("baud ticks", 16'(n >= 19 && n <= 22), 16'h0001);
		n = sel[4] ? u_pins.rx_cnt - rx0 : u_pins.tx_cnt - tx0;
		check("other ticks", 16'(n), 16'h0000);
		$display("test baud done");
	endtask

	task automatic t_clkout;
		int t0;
		load(8'hFC, 8'hFF, 8'hFC, 8'hFF);
		// count source clear, output enable set
		wr(MOD, 8'h02);
		wr(CTL, 8'h04);
		clocks(8);
		t0 = u_pins.toggles;
		clocks(160);
		check("pin driven", 16'(clk_oe_n), 16'h0000);
		check("toggles", 16'(u_pins.toggles - t0 >= 19 && u_pins.toggles - t0 <= 21), 16'h0001);
		rchk("clock out no flag", CTL, 8'h04);
		wr(CTL, 8'h00);
		wr(MOD, 8'h00);
		$display("test clock out done");
	endtask

	initial
	begin
		clocks(5);
		srst <= 1'b0;
		clocks(1);
		t_reset();
		t_timer();
		t_counter();
		t_trig(8'h0D, RHI, 8'hCD, 8'hFF);
		t_trig(8'h0C, CHI, 8'h4C, 8'h50);
		t_updown(1'b0, 8'h02, 8'h40, 8'h04, 8'hC4, 8'hFF);
		t_updown(1'b1, 8'hFE, 8'hFF, 8'h44, 8'h84, 8'h40);
		t_baud(8'h10);
		t_baud(8'h20);
		t_clkout();
		summarize();
	end

	initial
	begin
		clocks(20000);
		mismatches++;
		$display("watchdog expired");
		summarize();
	end
endmodule
